// *** verilog/vtp_pkg.sv ***
/*
 * Package for the vector table placement control block.
 * Assumes a 32-bit AXI4-Lite register bus and a 16-bit word program space.
 */
package vtp_pkg;
   localparam logic [3:0] VTP_ADDR_CTRL = 4'h0;
   localparam logic [3:0] VTP_ADDR_STAT = 4'h4;
   localparam int VTP_BIT_UNLOCK = 0;
   localparam int VTP_BIT_SELECT = 1;
   localparam int VTP_BIT_EXT2 = 5;
   localparam int VTP_BIT_EXT0 = 6;
   localparam int VTP_BIT_EXT1 = 7;
   localparam logic [7:0] VTP_CTRL_RESET = 8'h00;
   localparam logic [7:0] VTP_CTRL_RW_MASK = 8'he3;
   localparam logic [2:0] VTP_UNLOCK_CYCLES = 3'h4;
   localparam logic [15:0] VTP_VEC_TABLE_BASE = 16'h0001;
   localparam logic [1:0] VTP_RESP_OKAY = 2'h0;
   localparam logic [1:0] VTP_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      VTP_IDLE = 2'b00,
      VTP_OPEN = 2'b01,
      VTP_HOLD = 2'b10
   } vtp_state_t;
endpackage

// *** verilog/vtp_ctrl.sv ***
/*
 * Vector table placement control with AXI4-Lite register access.
 * Assumes synchronous fuse and lock inputs and a core that reports fetch
 * region and instruction completion each cycle.
 */
// Notes on behaviour
// - Vector base is flash start when select is zero, boot start if one.
// - Boot start address comes from the boot size fuses, not a register.
// - Unlock clears itself four cycles after set or on a select write.
// - Dispatch is blocked from unlock set until an instruction ends after the select write.
// - Without a select write dispatch stays blocked four cycles.
// - The blocking never touches the core's global interrupt flag.
// - Boot vectors plus application lock block irqs in application code.
// - App vectors plus loader lock block irqs in boot loader code.
// - Vector address is base plus offset; reset address follows fuse.
`timescale 1ns/1ps
module vtp_ctrl
   import vtp_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [ADDR_W-1:0] boot_size_fuses,
   input wire logic boot_reset_fuse,
   input wire logic application_side_lock_bit,
   input wire logic loader_side_lock_bit,
   input wire logic fetch_in_boot,
   input wire logic instr_done,
   input wire logic [4:0] vector_index,
   output logic [ADDR_W-1:0] vector_base,
   output logic [ADDR_W-1:0] vector_addr,
   output logic [ADDR_W-1:0] reset_addr,
   output logic irq_block,
   output logic ext_irq_zero_enable,
   output logic ext_irq_one_enable,
   output logic ext_irq_two_enable
);
   logic [7:0] ctrl_q, ctrl_d;
   vtp_state_t state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [3:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic wr_fire, wr_ctrl, sel_wr;

   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready = !w_q && !bv_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;

   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
         if (!s_axi_wstrb[0]) begin
            wd_d[7:0] = ctrl_q;
         end
      end
      wr_fire = aw_q && w_q;
      wr_ctrl = wr_fire && (awa_q[3:2] == VTP_ADDR_CTRL[3:2]);
      if (wr_fire) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = (awa_q[3:2] == VTP_ADDR_CTRL[3:2]) ? VTP_RESP_OKAY
                                                   : VTP_RESP_SLVERR;
      end else if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rr_d = VTP_RESP_OKAY;
         if (s_axi_araddr[3:2] == VTP_ADDR_CTRL[3:2]) begin
            rd_d = {24'h000000, ctrl_q};
         end else if (s_axi_araddr[3:2] == VTP_ADDR_STAT[3:2]) begin
            rd_d = {28'h0000000, cnt_q, irq_block};
         end else begin
            rd_d = 32'h00000000;
            rr_d = VTP_RESP_SLVERR;
         end
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 4'h0;
         wd_q <= 32'h00000000;
         bv_q <= 1'b0;
         br_q <= 2'h0;
         rv_q <= 1'b0;
         rd_q <= 32'h00000000;
         rr_q <= 2'h0;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
      end
   end

   always_comb begin
      ctrl_d = ctrl_q;
      state_d = state_q;
      cnt_d = cnt_q;
      sel_wr = wr_ctrl && ctrl_q[VTP_BIT_UNLOCK] && !wd_q[VTP_BIT_UNLOCK];
      if (wr_ctrl) begin
         ctrl_d[VTP_BIT_EXT0] = wd_q[VTP_BIT_EXT0];
         ctrl_d[VTP_BIT_EXT1] = wd_q[VTP_BIT_EXT1];
         ctrl_d[VTP_BIT_EXT2] = wd_q[VTP_BIT_EXT2];
      end
      case (state_q)
         VTP_IDLE: begin
            if (wr_ctrl && wd_q[VTP_BIT_UNLOCK]) begin
               ctrl_d[VTP_BIT_UNLOCK] = 1'b1;
               state_d = VTP_OPEN;
               cnt_d = VTP_UNLOCK_CYCLES;
            end
         end
         VTP_OPEN: begin
            if (sel_wr) begin
               ctrl_d[VTP_BIT_SELECT] = wd_q[VTP_BIT_SELECT];
               ctrl_d[VTP_BIT_UNLOCK] = 1'b0;
               state_d = VTP_HOLD;
               cnt_d = 3'h0;
            end else if (cnt_q == 3'h1) begin
               ctrl_d[VTP_BIT_UNLOCK] = 1'b0;
               state_d = VTP_IDLE;
               cnt_d = 3'h0;
            end else begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         VTP_HOLD: begin
            if (instr_done) begin
               state_d = VTP_IDLE;
            end
         end
         default: begin
            state_d = VTP_IDLE;
            ctrl_d = VTP_CTRL_RESET;
            cnt_d = 3'h0;
         end
      endcase
      ctrl_d = ctrl_d & VTP_CTRL_RW_MASK;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= VTP_CTRL_RESET;
         state_q <= VTP_IDLE;
         cnt_q <= 3'h0;
      end else begin
         ctrl_q <= ctrl_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Only this output gates dispatch; the core's global flag is untouched.
   assign irq_block = (state_q != VTP_IDLE)
      || (ctrl_q[VTP_BIT_SELECT] && application_side_lock_bit
          && !fetch_in_boot)
      || (!ctrl_q[VTP_BIT_SELECT] && loader_side_lock_bit
          && fetch_in_boot);
   assign vector_base = ctrl_q[VTP_BIT_SELECT] ? boot_size_fuses
                                               : '0;
   assign vector_addr = vector_base + VTP_VEC_TABLE_BASE[ADDR_W-1:0]
      + ADDR_W'(vector_index);
   assign reset_addr = boot_reset_fuse ? '0 : boot_size_fuses;
   assign ext_irq_zero_enable = ctrl_q[VTP_BIT_EXT0];
   assign ext_irq_one_enable = ctrl_q[VTP_BIT_EXT1];
   assign ext_irq_two_enable = ctrl_q[VTP_BIT_EXT2];

   // A select value is taken only in the open window; else it is dropped.
   hold_sel_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (state_q == VTP_IDLE) |=> $stable(ctrl_q[VTP_BIT_SELECT]))
      else $error("select changed outside unlock window");
   unlock_blocks_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ctrl_q[VTP_BIT_UNLOCK] |-> irq_block)
      else $error("dispatch not blocked during unlock");
   unlock_timeout_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(ctrl_q[VTP_BIT_UNLOCK]) |-> ##[1:4] !ctrl_q[VTP_BIT_UNLOCK])
      else $error("unlock not cleared in four cycles");
   sel_clears_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      sel_wr |=> !ctrl_q[VTP_BIT_UNLOCK] && state_q == VTP_HOLD)
      else $error("select write did not close unlock");
   base_map_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      vector_base == (ctrl_q[VTP_BIT_SELECT] ? boot_size_fuses : '0))
      else $error("vector base mismatch");

   // After a select write, dispatch stays blocked until an instruction ends.
   sequence sel_taken_s;
      sel_wr;
   endsequence
   sequence held_till_done_s;
      irq_block && !instr_done;
   endsequence
   hold_until_done_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      sel_taken_s ##1 held_till_done_s |=> irq_block)
      else $error("dispatch released before instruction ended");
   sel_guard_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $changed(ctrl_q[VTP_BIT_SELECT]) |-> $past(sel_wr))
      else $error("select changed without unlock");
endmodule

// *** verif/vtp_core_model.sv ***
/*
 * Core model: fetch region and instruction completion pulse.
 * Assumes the bench drives want_boot and step after rising edges.
 */
`timescale 1ns/1ps
module vtp_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic want_boot,
   input wire logic step,
   output logic fetch_in_boot,
   output logic instr_done
);
   logic boot_q, boot_d, done_q, done_d;
   always_comb begin
      boot_d = want_boot;
      done_d = step && !done_q;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         boot_q <= boot_d;
         done_q <= done_d;
      end
   end
   assign fetch_in_boot = boot_q;
   assign instr_done = done_q;
endmodule

// *** verif/vector_table_placement_control_tb_top.sv ***
/*
 * Testbench for vtp_ctrl over AXI4-Lite.
 * Assumes the package and the core model are compiled first.
 */
`timescale 1ns/1ps
module vector_table_placement_control_tb_top
   import vtp_pkg::*;
;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
   logic awready, wready, bvalid, arready, rvalid, blk, done, in_boot;
   logic app_lock = 0, ldr_lock = 0, rst_fuse = 1, want_boot = 0, step = 0;
   logic [3:0] strb = 4'hf;
   logic [4:0] idx = 5'h03;
   logic [15:0] fuses = 16'h0c00;
   logic [2:0] ext;
   logic [3:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, got_data;
   logic [1:0] bresp, rresp, got_resp;
   logic [15:0] vbase, vaddr, raddr;
   int mismatches = 0, checked = 0;
   always #50 aclk = ~aclk;
   vtp_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .boot_size_fuses(fuses), .boot_reset_fuse(rst_fuse),
      .application_side_lock_bit(app_lock), .loader_side_lock_bit(ldr_lock),
      .fetch_in_boot(in_boot), .instr_done(done), .vector_index(idx),
      .vector_base(vbase), .vector_addr(vaddr), .reset_addr(raddr),
      .irq_block(blk), .ext_irq_zero_enable(ext[0]),
      .ext_irq_one_enable(ext[1]), .ext_irq_two_enable(ext[2]));
   vtp_core_model core_u (.aclk(aclk), .aresetn(aresetn),
      .want_boot(want_boot), .step(step), .fetch_in_boot(in_boot),
      .instr_done(done));
   task summarize;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task tmo(input int n);
      if (n >= 20) begin
         mismatches++;
         summarize;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      int n;
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
         if (aw_ok && w_ok) break;
      end
      tmo(n);
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (bvalid) break;
      end
      tmo(n);
      got_resp = bresp;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (arready) break;
      end
      tmo(n);
      arvalid <= 1'b0;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (rvalid) break;
      end
      tmo(n);
      got_data = rdata;
      got_resp = rresp;
      #1;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   task pulse;
      step <= 1'b1;
      @(posedge aclk);
      step <= 1'b0;
      cyc(2);
   endtask
   initial begin
      cyc(2);
      aresetn <= 1'b1;
      rd(VTP_ADDR_CTRL);
      chk("ctrl", 32'h0, got_data);
      chk("vaddr", 32'h4, vaddr);
      chk("raddr", 32'h0, raddr);
      wr(VTP_ADDR_CTRL, 8'he2);
      chk("bresp", VTP_RESP_OKAY, got_resp);
      rd(VTP_ADDR_CTRL);
      chk("ctrl", 32'he0, got_data);
      chk("ext", 32'h7, ext);
      strb <= 4'h0;
      wr(VTP_ADDR_CTRL, 8'h00);
      strb <= 4'hf;
      rd(VTP_ADDR_CTRL);
      chk("ctrl", 32'he0, got_data);
      $display("test reset and lock done");
      wr(VTP_ADDR_CTRL, 8'he1);
      chk("blk", 32'h1, blk);
      cyc(5);
      chk("blk", 32'h0, blk);
      rd(VTP_ADDR_CTRL);
      chk("ctrl", 32'he0, got_data);
      $display("test unlock expiry done");
      wr(VTP_ADDR_CTRL, 8'h01);
      wr(VTP_ADDR_CTRL, 8'h02);
      cyc(6);
      chk("blk", 32'h1, blk);
      rd(VTP_ADDR_STAT);
      chk("stat", 32'h1, got_data);
      rd(VTP_ADDR_CTRL);
      chk("ctrl", 32'h02, got_data);
      chk("vbase", 32'hc00, vbase);
      chk("vaddr", 32'hc04, vaddr);
      fuses <= 16'h0e00;
      idx <= 5'h10;
      cyc(1);
      chk("vbase", 32'he00, vbase);
      chk("vaddr", 32'he11, vaddr);
      chk("raddr", 32'h0, raddr);
      fuses <= 16'h0c00;
      idx <= 5'h03;
      pulse;
      chk("blk", 32'h0, blk);
      app_lock <= 1'b1;
      cyc(1);
      chk("blk", 32'h1, blk);
      want_boot <= 1'b1;
      cyc(2);
      chk("blk", 32'h0, blk);
      $display("test move to boot done");
      wr(VTP_ADDR_CTRL, 8'h01);
      wr(VTP_ADDR_CTRL, 8'h00);
      pulse;
      chk("vaddr", 32'h4, vaddr);
      ldr_lock <= 1'b1;
      cyc(1);
      chk("blk", 32'h1, blk);
      want_boot <= 1'b0;
      rst_fuse <= 1'b0;
      cyc(2);
      chk("blk", 32'h0, blk);
      chk("raddr", 32'hc00, raddr);
      rd(4'h8);
      chk("rresp", VTP_RESP_SLVERR, got_resp);
      chk("rdata", 32'h0, got_data);
      wr(4'h8, 8'h5a);
      chk("bresp", VTP_RESP_SLVERR, got_resp);
      $display("test move back done");
      summarize;
   end
endmodule
